// File: idr_conv_timer.sv
// conversion timer: runs one measurement of fixed length and pulses done
`timescale 1ns/1ns
module idr_conv_timer
    import idr_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic          busy_q;
    logic          busy_d;
    logic          done_q;
    logic          done_d;

    // a start while busy is ignored; the running measurement completes
    always_comb begin
        count_d = count_q;
        busy_d  = busy_q;
        done_d  = 1'b0;
        if (busy_q) begin
            if (count_q == LAST) begin
                busy_d  = 1'b0;
                done_d  = 1'b1;
                count_d = '0;
            end else begin
                count_d = count_q + CW'(1);
            end
        end else if (i_start) begin
            busy_d  = 1'b1;
            count_d = '0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            count_q <= '0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;

endmodule

// File: idr_link_model.sv
// link-side model: single-byte register reads and writes
`timescale 1ns/1ns
module idr_link_model
    import idr_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output idr_access_type  o_acc
);
    initial o_acc = '0;
    // unused address form carries inverted junk, never a copy of the real one
    task automatic access(input logic rd, input logic ext, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic v);
        logic conv;
        // reserved bit 5 is held low only for the conversion register
        conv = (a >= ADDR_CONV_WRITE) && (a <= ADDR_CONV_CLEAR);
        @(posedge i_ref_clk);
        o_acc <= '{rd: rd, wr: !rd, ext: ext, imm_addr: ext ? ~a[5:0] : a[5:0],
                   ext_addr: ext ? a : ~a, wdata: rd ? 8'h00 : (conv ? (d & 8'hdf) : d)};
        @(posedge i_ref_clk);
        o_acc <= '0;
        // the answer stands until this edge's update, so take it here
        @(posedge i_ref_clk);
        q = i_rd_data;
        v = i_rd_valid;
    endtask
endmodule

// File: idr_pkg.sv
// package: offsets, fields, reset values and timing for the id resistor register bank
package idr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_KIT_IRQ_STATUS = 8'h20;
    localparam logic [7:0] ADDR_KIT_IRQ_LATCH  = 8'h21;
    localparam logic [7:0] ADDR_HS_TX_AMP      = 8'h31;
    localparam logic [7:0] ADDR_HEADSET_AUDIO  = 8'h33;
    localparam logic [7:0] ADDR_CONV_WRITE     = 8'h36;
    localparam logic [7:0] ADDR_CONV_SET       = 8'h37;
    localparam logic [7:0] ADDR_CONV_CLEAR     = 8'h38;
    localparam logic [7:0] ADDR_IMM_LAST       = 8'h3f;

    // status register fields
    localparam int ST_OPEN_BIT  = 0;
    localparam int ST_ATTACH    = 1;
    localparam int ST_DPLUS     = 2;
    localparam int ST_CODE_LSB  = 3;
    localparam int ST_DONE_BIT  = 6;

    // latch register fields
    localparam int LT_OPEN_BIT  = 0;
    localparam int LT_CONV_BIT  = 3;

    // conversion register fields
    localparam int CV_CODE_LSB  = 0;
    localparam int CV_DONE_BIT  = 3;
    localparam int CV_GO_BIT    = 4;
    localparam int CV_RSVD_BIT  = 5;
    localparam int CV_IRQ_BIT   = 6;

    // amplitude and headset fields
    localparam int AMP_LSB      = 5;
    localparam int KEY_LSB      = 0;
    localparam logic [3:0] HEADSET_KEY = 4'ha;

    // resistance codes
    localparam logic [2:0] CODE_ZERO   = 3'h0;
    localparam logic [2:0] CODE_R75    = 3'h1;
    localparam logic [2:0] CODE_R100K  = 3'h2;
    localparam logic [2:0] CODE_R200K  = 3'h3;
    localparam logic [2:0] CODE_R440K  = 3'h4;
    localparam logic [2:0] CODE_OPEN   = 3'h5;
    localparam logic [2:0] CODE_ERROR  = 3'h7;

    // drive strength selections
    localparam logic [1:0] AMP_NOMINAL = 2'h0;
    localparam logic [1:0] AMP_PLUS_74 = 2'h2;
    localparam logic [1:0] AMP_PLUS_37 = 2'h3;

    // reset values
    localparam logic [7:0] REG_RESET   = 8'h00;

    // conversion timing
    localparam int CLK_HZ          = 10_000_000;
    localparam int CONV_TIME_US    = 282;
    localparam int CONV_CYCLES     = (CONV_TIME_US * (CLK_HZ / 1_000_000));

    // one register access taken from the ulpi front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ext;
        logic [5:0] imm_addr;
        logic [7:0] ext_addr;
        logic [7:0] wdata;
    } idr_access_type;

endpackage

// File: idr_regs.sv
// id resistor, kit interrupt, amplitude and headset key register bank
`timescale 1ns/1ns
module idr_regs
    import idr_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_reset,
    input  wire idr_access_type i_acc,
    input  wire logic           i_id_open,
    input  wire logic [2:0]     i_id_res_code,
    input  wire logic           i_open_rise_enable,
    input  wire logic           i_open_fall_enable,
    input  wire logic           i_kit_conv_irq_enable,
    output logic [7:0]          o_rd_data,
    output logic                o_rd_valid,
    output logic                o_rd_hit,
    output logic                o_alt_int,
    output logic                o_id_conv_run,
    output logic [1:0]          o_hs_drive_sel,
    output logic                o_headset_audio_en
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [7:0] addr;
    logic       sel_status;
    logic       sel_latch;
    logic       sel_amp;
    logic       sel_key;
    logic       sel_conv;

    // both address forms land on one map
    always_comb begin
        addr       = i_acc.ext ? i_acc.ext_addr : {2'b00, i_acc.imm_addr};
        sel_status = (addr == ADDR_KIT_IRQ_STATUS);
        sel_latch  = (addr == ADDR_KIT_IRQ_LATCH);
        sel_amp    = (addr == ADDR_HS_TX_AMP);
        sel_key    = (addr == ADDR_HEADSET_AUDIO);
        sel_conv   = (addr >= ADDR_CONV_WRITE) && (addr <= ADDR_CONV_CLEAR);
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion timer

    logic conv_busy;
    logic conv_done;
    logic conv_start;
    logic go_q;
    logic go_d;

    // go is still high in the done cycle; without this gate the timer relaunches
    assign conv_start = go_q && !conv_done;

    idr_conv_timer #(
        .CYCLES (CONV_LEN)
    ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_start   (conv_start),
        .o_busy    (conv_busy),
        .o_done    (conv_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // conversion register and done flag

    logic [2:0] code_q;
    logic [2:0] code_d;
    logic       done_q;
    logic       done_d;
    logic       rsvd5_q;
    logic       rsvd5_d;
    logic       irq_en_q;
    logic       irq_en_d;
    logic [7:0] conv_img;
    logic [7:0] conv_new;

    // write, set and clear share one image; go, code and done change by hardware
    always_comb begin
        conv_img = REG_RESET;
        conv_img[CV_CODE_LSB +: 3] = code_q;
        conv_img[CV_DONE_BIT]      = done_q;
        conv_img[CV_GO_BIT]        = go_q;
        conv_img[CV_RSVD_BIT]      = rsvd5_q;
        conv_img[CV_IRQ_BIT]       = irq_en_q;
        unique case (addr)
            ADDR_CONV_SET:   conv_new = conv_img | i_acc.wdata;
            ADDR_CONV_CLEAR: conv_new = conv_img & ~i_acc.wdata;
            default:         conv_new = i_acc.wdata;
        endcase
        code_d   = code_q;
        go_d     = go_q;
        rsvd5_d  = rsvd5_q;
        irq_en_d = irq_en_q;
        done_d   = done_q;
        if (i_acc.wr && sel_conv) begin
            code_d   = conv_new[CV_CODE_LSB +: 3];
            go_d     = conv_new[CV_GO_BIT];
            rsvd5_d  = conv_new[CV_RSVD_BIT];
            irq_en_d = conv_new[CV_IRQ_BIT];
        end
        // go is held until the timer takes it, then drops at done
        if (conv_busy && go_q && !(i_acc.wr && sel_conv)) begin
            go_d = go_q;
        end
        if (i_acc.rd && sel_conv) begin
            done_d = 1'b0;
        end
        if (conv_done) begin
            go_d   = 1'b0;
            code_d = i_id_res_code;
            done_d = 1'b1;                           // set beats read clear
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            code_q   <= CODE_ZERO;
            go_q     <= 1'b0;
            rsvd5_q  <= 1'b0;
            irq_en_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            code_q   <= code_d;
            go_q     <= go_d;
            rsvd5_q  <= rsvd5_d;
            irq_en_q <= irq_en_d;
            done_q   <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event detection and interrupt latch

    logic open_prev_q;
    logic done_prev_q;
    logic lt_open_q;
    logic lt_open_d;
    logic lt_conv_q;
    logic lt_conv_d;
    logic conv_irq_en;
    logic open_evt;
    logic conv_evt;
    logic alt_int_d;

    // events set, a latch read clears, and a same-cycle event survives the read
    always_comb begin
        conv_irq_en = irq_en_q | i_kit_conv_irq_enable;
        open_evt    = (i_id_open && !open_prev_q && i_open_rise_enable)
                   || (!i_id_open && open_prev_q && i_open_fall_enable);
        conv_evt    = done_q && !done_prev_q && conv_irq_en;
        lt_open_d   = lt_open_q;
        lt_conv_d   = lt_conv_q;
        if (i_acc.rd && sel_latch) begin
            lt_open_d = 1'b0;
            lt_conv_d = 1'b0;
        end
        if (open_evt) begin
            lt_open_d = 1'b1;
        end
        if (conv_evt) begin
            lt_conv_d = 1'b1;
        end
        alt_int_d = lt_open_d | lt_conv_d;
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            open_prev_q <= 1'b0;
            done_prev_q <= 1'b0;
            lt_open_q   <= 1'b0;
            lt_conv_q   <= 1'b0;
            o_alt_int   <= 1'b0;
        end else begin
            open_prev_q <= i_id_open;
            done_prev_q <= done_q;
            lt_open_q   <= lt_open_d;
            lt_conv_q   <= lt_conv_d;
            o_alt_int   <= alt_int_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // amplitude trim and headset key

    logic [1:0] amp_q;
    logic [1:0] amp_d;
    logic [3:0] key_q;
    logic [3:0] key_d;

    // plain read/write registers; reserved bits are not stored
    always_comb begin
        amp_d = amp_q;
        key_d = key_q;
        if (i_acc.wr && sel_amp) begin
            amp_d = i_acc.wdata[AMP_LSB +: 2];
        end
        if (i_acc.wr && sel_key) begin
            key_d = i_acc.wdata[KEY_LSB +: 4];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            amp_q              <= AMP_NOMINAL;
            key_q              <= 4'h0;
            o_hs_drive_sel     <= AMP_NOMINAL;
            o_headset_audio_en <= 1'b0;
        end else begin
            amp_q              <= amp_d;
            key_q              <= key_d;
            o_hs_drive_sel     <= amp_d;
            o_headset_audio_en <= (key_d == HEADSET_KEY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    logic [7:0] rd_d;
    logic       hit_d;

    // status read is side-effect free; unmapped reads return zero
    always_comb begin
        rd_d  = REG_RESET;
        hit_d = 1'b1;
        if (sel_status) begin
            rd_d[ST_OPEN_BIT]        = i_id_open;
            rd_d[ST_ATTACH]          = 1'b0;
            rd_d[ST_DPLUS]           = 1'b0;
            rd_d[ST_CODE_LSB +: 3]   = code_q;
            rd_d[ST_DONE_BIT]        = done_q;
        end else if (sel_latch) begin
            rd_d[LT_OPEN_BIT]        = lt_open_q;
            rd_d[LT_CONV_BIT]        = lt_conv_q;    // others zero
        end else if (sel_amp) begin
            rd_d[AMP_LSB +: 2]       = amp_q;
        end else if (sel_key) begin
            rd_d[KEY_LSB +: 4]       = key_q;
        end else if (sel_conv) begin
            rd_d                     = conv_img;
        end else begin
            hit_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data     <= REG_RESET;
            o_rd_valid    <= 1'b0;
            o_rd_hit      <= 1'b0;
            o_id_conv_run <= 1'b0;
        end else begin
            o_rd_data     <= i_acc.rd ? rd_d : REG_RESET;
            o_rd_valid    <= i_acc.rd;
            o_rd_hit      <= i_acc.rd && hit_d;
            o_id_conv_run <= conv_busy;
        end
    end

endmodule

// File: idr_regs_checker.sv
// checker: port timing and value relations of the register bank
`timescale 1ns/1ns
module idr_regs_checker
    import idr_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input  wire logic           i_ref_clk,
    input  wire logic           i_reset,
    input  wire idr_access_type i_acc,
    input  wire logic           i_id_open,
    input  wire logic           i_open_rise_enable,
    input  wire logic           i_open_fall_enable,
    input  wire logic           i_kit_conv_irq_enable,
    input  wire logic [7:0]     o_rd_data,
    input  wire logic           o_rd_valid,
    input  wire logic           o_rd_hit,
    input  wire logic           o_alt_int,
    input  wire logic           o_id_conv_run,
    input  wire logic [1:0]     o_hs_drive_sel,
    input  wire logic           o_headset_audio_en
);
    logic [7:0] addr;
    logic       mapped;
    logic [1:0] amp_q, amp_d;
    logic [3:0] key_q, key_d;
    logic       ien_q, ien_d;
    int         cnt_q, cnt_d;
    ////////////////////////////////////////////////////////////
    // effective address, same selection as the front end
    assign addr = i_acc.ext ? i_acc.ext_addr : {2'h0, i_acc.imm_addr};
    assign mapped = addr inside {ADDR_KIT_IRQ_STATUS, ADDR_KIT_IRQ_LATCH, ADDR_HS_TX_AMP,
        ADDR_HEADSET_AUDIO, ADDR_CONV_WRITE, ADDR_CONV_SET, ADDR_CONV_CLEAR};
    // shadow of written fields; run counter measures the measurement length
    always_comb begin
        amp_d = amp_q;
        key_d = key_q;
        ien_d = ien_q;
        cnt_d = o_id_conv_run ? cnt_q + 1 : 0;
        if (i_acc.wr) begin
            if (addr == ADDR_HS_TX_AMP) amp_d = i_acc.wdata[6:5];
            if (addr == ADDR_HEADSET_AUDIO) key_d = i_acc.wdata[3:0];
            if (addr == ADDR_CONV_WRITE) ien_d = i_acc.wdata[CV_IRQ_BIT];
            if (addr == ADDR_CONV_SET) ien_d = ien_q | i_acc.wdata[CV_IRQ_BIT];
            if (addr == ADDR_CONV_CLEAR) ien_d = ien_q & ~i_acc.wdata[CV_IRQ_BIT];
        end
    end
    // helper registers
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            amp_q <= 2'h0;
            key_q <= 4'h0;
            ien_q <= 1'b0;
            cnt_q <= 0;
        end else begin
            amp_q <= amp_d;
            key_q <= key_d;
            ien_q <= ien_d;
            cnt_q <= cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_read_hit: assert property (i_acc.rd && mapped |=> o_rd_valid && o_rd_hit)
        else $error("mapped read not answered");
    a_unmapped_zero: assert property (i_acc.rd && !mapped |=> o_rd_valid && !o_rd_hit
        && o_rd_data == 8'h00) else $error("unmapped read not zero");
    a_status_rsvd: assert property (i_acc.rd && addr == ADDR_KIT_IRQ_STATUS
        |=> o_rd_data[7] == 1'b0 && o_rd_data[2:1] == 2'h0) else $error("status reserved");
    a_latch_rsvd: assert property (i_acc.rd && addr == ADDR_KIT_IRQ_LATCH
        |=> o_rd_data[7:4] == 4'h0 && o_rd_data[2:1] == 2'h0) else $error("latch reserved");
    a_drive_follow: assert property (i_acc.wr && addr == ADDR_HS_TX_AMP
        |-> ##2 o_hs_drive_sel == amp_q) else $error("drive select wrong");
    a_key_gate: assert property (i_acc.wr && addr == ADDR_HEADSET_AUDIO
        |-> ##2 o_headset_audio_en == (key_q == HEADSET_KEY)) else $error("key gate wrong");
    a_conv_start: assert property (i_acc.wr && addr == ADDR_CONV_SET
        && i_acc.wdata[CV_GO_BIT] && !o_id_conv_run |-> ##[2:3] o_id_conv_run)
        else $error("measurement not launched");
    a_conv_length: assert property ($fell(o_id_conv_run) |-> cnt_q == CONV_LEN)
        else $error("measurement length wrong");
    a_conv_irq: assert property ($fell(o_id_conv_run)
        && (ien_q || i_kit_conv_irq_enable) |-> ##[0:6] o_alt_int) else $error("no conv irq");
    a_open_irq: assert property (($rose(i_id_open) && i_open_rise_enable)
        || ($fell(i_id_open) && i_open_fall_enable) |-> ##[1:3] o_alt_int)
        else $error("no open irq");
endmodule

bind idr_regs idr_regs_checker #(.CONV_LEN(CONV_LEN)) u_chk (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_acc(i_acc), .i_id_open(i_id_open),
    .i_open_rise_enable(i_open_rise_enable), .i_open_fall_enable(i_open_fall_enable),
    .i_kit_conv_irq_enable(i_kit_conv_irq_enable), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit), .o_alt_int(o_alt_int),
    .o_id_conv_run(o_id_conv_run), .o_hs_drive_sel(o_hs_drive_sel),
    .o_headset_audio_en(o_headset_audio_en));

// File: tb_id_resistor_kit_irq_regs.sv
// testbench for the id resistor and kit interrupt register bank
`timescale 1ns/1ns
module tb_id_resistor_kit_irq_regs;
    import idr_pkg::*;
    localparam int LEN = 20;
    logic           clk, rst, open, ren, fen, ken, alt, run, hs_en, rvalid;
    logic [2:0]     code;
    logic [1:0]     drv;
    logic [7:0]     rdata;
    idr_access_type acc;
    int             n_errors = 0;
    int             tests_run = 0;
    int             cyc = 0;
    ////////////////////////////////////////////////////////////
    idr_regs #(.CONV_LEN(LEN)) dut (.i_ref_clk(clk), .i_reset(rst), .i_acc(acc),
        .i_id_open(open), .i_id_res_code(code), .i_open_rise_enable(ren),
        .i_open_fall_enable(fen), .i_kit_conv_irq_enable(ken), .o_rd_data(rdata),
        .o_rd_valid(rvalid), .o_rd_hit(), .o_alt_int(alt), .o_id_conv_run(run),
        .o_hs_drive_sel(drv), .o_headset_audio_en(hs_en));
    idr_link_model u_link (.i_ref_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid),
        .o_acc(acc));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read through the link model and compare data and answer strobe
    task automatic rd(input logic [7:0] a, input logic ext, input logic [7:0] exp);
        logic [7:0] q;
        logic       v;
        u_link.access(1'b1, ext, a, 8'h00, q, v);
        check({7'h0, v}, 8'h01);
        check(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic ext, input logic [7:0] d);
        logic [7:0] q;
        logic       v;
        u_link.access(1'b0, ext, a, d, q, v);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] regs [7] = '{ADDR_KIT_IRQ_STATUS, ADDR_KIT_IRQ_LATCH, ADDR_HS_TX_AMP,
            ADDR_HEADSET_AUDIO, ADDR_CONV_WRITE, ADDR_CONV_SET, ADDR_CONV_CLEAR};
        foreach (regs[i]) rd(regs[i], 1'b0, REG_RESET);
        wr(ADDR_KIT_IRQ_LATCH, 1'b0, 8'hff);
        rd(ADDR_KIT_IRQ_LATCH, 1'b1, 8'h00);
        rd(8'h30, 1'b0, 8'h00);
        rd(8'h9a, 1'b1, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_amp_key;
        logic [3:0] keys [4] = '{HEADSET_KEY, 4'h5, 4'hb, 4'h0};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_HS_TX_AMP, i[0], {1'b1, i[1:0], 5'h1f});
            rd(ADDR_HS_TX_AMP, !i[0], {1'b0, i[1:0], 5'h00});
            check({6'h0, drv}, {6'h0, i[1:0]});
            wr(ADDR_HEADSET_AUDIO, i[0], {4'hf, keys[i]});
            rd(ADDR_HEADSET_AUDIO, 1'b0, {4'h0, keys[i]});
            check({7'h0, hs_en}, {7'h0, keys[i] == HEADSET_KEY});
        end
        $display("amplitude and key done");
    endtask
    // one measurement; the irq enable is either the local bit or the outside one
    task automatic t_conv(input logic ext_en, input logic [2:0] c);
        logic [7:0] irq;
        irq = ext_en ? 8'h00 : 8'h40;
        @(posedge clk);
        ken <= ext_en;
        code <= c;
        wr(ADDR_CONV_WRITE, 1'b0, irq);
        wr(ADDR_CONV_SET, 1'b0, 8'h10);
        rd(ADDR_CONV_CLEAR, 1'b0, irq | 8'h10);
        repeat (LEN + 8) @(posedge clk);
        rd(ADDR_KIT_IRQ_STATUS, 1'b0, {2'b01, c, 3'b000});
        rd(ADDR_KIT_IRQ_STATUS, 1'b1, {2'b01, c, 3'b000});
        check({7'h0, alt}, 8'h01);
        rd(ADDR_KIT_IRQ_LATCH, 1'b0, 8'h08);
        rd(ADDR_KIT_IRQ_LATCH, 1'b0, 8'h00);
        check({7'h0, alt}, 8'h00);
        rd(ADDR_CONV_SET, 1'b0, irq | 8'h08 | {5'h0, c});
        rd(ADDR_CONV_WRITE, 1'b0, irq | {5'h0, c});
        rd(ADDR_KIT_IRQ_STATUS, 1'b0, {2'b00, c, 3'b000});
        wr(ADDR_CONV_CLEAR, 1'b0, 8'h40);
        rd(ADDR_CONV_WRITE, 1'b0, {5'h0, c});
        @(posedge clk);
        ken <= 1'b0;
        $display("conversion done, code %0d", c);
    endtask
    task automatic t_open;
        // the last measurement leaves its code in the status byte; clear it first
        wr(ADDR_CONV_WRITE, 1'b0, 8'h00);
        @(posedge clk);
        ren <= 1'b1;
        @(posedge clk);
        open <= 1'b1;
        rd(ADDR_KIT_IRQ_STATUS, 1'b0, 8'h01);
        rd(ADDR_KIT_IRQ_LATCH, 1'b0, 8'h01);
        @(posedge clk);
        ren <= 1'b0;
        fen <= 1'b1;
        @(posedge clk);
        open <= 1'b0;
        repeat (3) @(posedge clk);
        check({7'h0, alt}, 8'h01);
        rd(ADDR_KIT_IRQ_LATCH, 1'b0, 8'h01);
        @(posedge clk);
        fen <= 1'b0;
        @(posedge clk);
        open <= 1'b1;
        rd(ADDR_KIT_IRQ_LATCH, 1'b0, 8'h00);
        $display("float detect done");
    endtask
    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            $display("BAD %0t timeout", $time);
            complete_run();
        end
    end
    initial begin
        logic [2:0] codes [7] = '{CODE_ZERO, CODE_R75, CODE_R100K, CODE_R200K, CODE_R440K,
            CODE_OPEN, CODE_ERROR};
        {rst, open, ren, fen, ken, code} = {1'b1, 7'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_amp_key();
        foreach (codes[i]) t_conv(i[0], codes[i]);
        t_open();
        complete_run();
    end
endmodule
